// >>> dv/sdbs_ctrl_model.sv
// Machine safety controller and brake side driving the pins.
// Assumes the bench calls its tasks; levels held 5 clocks for sync.
`timescale 1ns/1ns
`default_nettype none
// ****************************************************
// Controller model
// ****************************************************
module sdbs_ctrl_model (
   input wire logic mclk_in,
   output var logic chan_a_out,
   output var logic chan_b_out,
   output var logic fs_ack_out,
   output var logic [15:0] cw1_out,
   output var logic run_out,
   output var logic qstop_n_out,
   output var logic still_out,
   output var logic [3:0] diag_out
);
   // Idle: deselected, no pulses, motor off, at standstill
   initial begin
      chan_a_out = 1'b1;
      chan_b_out = 1'b1;
      fs_ack_out = 1'b0;
      cw1_out = 16'h0003;
      run_out = 1'b0;
      qstop_n_out = 1'b1;
      still_out = 1'b1;
      diag_out = 4'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // Every change is held long enough for the two-flop sync
   task automatic set_ch(input logic a, input logic b);
      @(posedge mclk_in);
      chan_a_out <= a;
      chan_b_out <= b;
      tick(5);
   endtask
   task automatic ack_terms();
      set_ch(1'b0, 1'b0);
      set_ch(1'b1, 1'b1);
   endtask
   task automatic set_cw(input int b, input logic v);
      @(posedge mclk_in);
      cw1_out[b] <= v;
      tick(5);
   endtask
   task automatic pulse_cw(input int b);
      set_cw(b, !cw1_out[b]);
      set_cw(b, !cw1_out[b]);
   endtask
   task automatic pulse_ack();
      @(posedge mclk_in);
      fs_ack_out <= 1'b1;
      tick(5);
      fs_ack_out <= 1'b0;
      tick(5);
   endtask
   // Run low then high, after the bench's standard acknowledge
   task automatic restart();
      @(posedge mclk_in);
      run_out <= 1'b0;
      tick(5);
      run_out <= 1'b1;
      tick(5);
   endtask
   // Standstill first, torque off later is the bench's order
   task automatic set_still(input logic v);
      @(posedge mclk_in);
      still_out <= v;
      tick(5);
   endtask
   task automatic set_qstop(input logic v);
      @(posedge mclk_in);
      qstop_n_out <= v;
      tick(5);
   endtask
   task automatic set_diag(input logic [3:0] v);
      @(posedge mclk_in);
      diag_out <= v;
      tick(5);
   endtask
endmodule // sdbs_ctrl_model
`default_nettype wire

// >>> dv/sdbs_properties.sv
// Checker for the discrepancy and brake supervisor port behaviour.
// Assumes bind onto sdbs_top; one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
// ****************************************************
// Port relations
// ****************************************************
module sdbs_properties (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic failsafe_digital_input_a_in,
   input wire logic failsafe_digital_input_b_in,
   input wire logic [3:0] brake_diag_in,
   input wire logic safe_torque_off_out,
   input wire logic safe_brake_control_out,
   input wire logic brake_close_out,
   input wire logic motor_on_out,
   input wire logic stop_a_out,
   input wire logic discrepancy_fault_out,
   input wire logic brake_fault_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   // Read of an unmapped word, address phase taken
   wire logic rd_hole;
   assign rd_hole = hsel && htrans[1] && hready && !hwrite &&
      haddr == 32'h0000_0100;
   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   property p_hole_zero;
      rd_hole |=> hrdata == 32'h0000_0000;
   endproperty
   // Sync delay of two flops plus one leaves room of four edges
   property p_disc_sto;
      (failsafe_digital_input_a_in != failsafe_digital_input_b_in) |->
         ##[0:4] safe_torque_off_out;
   endproperty
   property p_sbc_sto;
      safe_brake_control_out |-> safe_torque_off_out && brake_close_out;
   endproperty
   property p_no_start;
      $rose(motor_on_out) |-> !safe_torque_off_out;
   endproperty
   property p_bf_detect;
      (brake_diag_in != 4'h0) |-> ##[1:4] brake_fault_out;
   endproperty
   property p_bf_resp;
      brake_fault_out |-> stop_a_out && brake_close_out;
   endproperty
   property p_df_sto;
      $rose(discrepancy_fault_out) |-> safe_torque_off_out;
   endproperty
   a_bus_okay: assert property (p_bus_okay)
      else $error("bus answer not ready or not okay");
   a_hole_zero: assert property (p_hole_zero)
      else $error("unmapped read not zero");
   a_disc_sto: assert property (p_disc_sto)
      else $error("disagreeing channels without torque off");
   a_sbc_sto: assert property (p_sbc_sto)
      else $error("brake control without torque off or closed brake");
   a_no_start: assert property (p_no_start)
      else $error("motor switched on under torque off");
   a_bf_detect: assert property (p_bf_detect)
      else $error("brake circuit fault not flagged");
   a_bf_resp: assert property (p_bf_resp)
      else $error("brake fault without stop or closed brake");
   a_df_sto: assert property (p_df_sto)
      else $error("discrepancy fault without torque off");
   c_motor: cover property ($rose(motor_on_out));
   c_disc: cover property ($rose(discrepancy_fault_out));
   c_brake: cover property ($rose(brake_fault_out));
   c_sbc: cover property ($rose(safe_brake_control_out));
endmodule // sdbs_properties
bind sdbs_top sdbs_properties u_props (.mclk_in(mclk_in),
   .reset_n_in(reset_n_in), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp),
   .failsafe_digital_input_a_in(failsafe_digital_input_a_in),
   .failsafe_digital_input_b_in(failsafe_digital_input_b_in),
   .brake_diag_in(brake_diag_in), .safe_torque_off_out(safe_torque_off_out),
   .safe_brake_control_out(safe_brake_control_out),
   .brake_close_out(brake_close_out), .motor_on_out(motor_on_out),
   .stop_a_out(stop_a_out), .discrepancy_fault_out(discrepancy_fault_out),
   .brake_fault_out(brake_fault_out));
`default_nettype wire

// >>> dv/tb.sv
// Testbench: register and pin sequences against the supervisor.
// Assumes one AHB-Lite slave answering at once; 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`include "sdbs_defines.vh"
// ****************************************************
// Bench top
// ****************************************************
module tb;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0, hsel = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] rd;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, ch_a, ch_b, fs_ack, run, qstop_n, still;
   wire logic [15:0] cw1;
   wire logic [3:0] diag;
   wire logic safe_torque_off, safe_brake_control, close, ramp, motor, stop_a, dfault, bfault;
   int fails = 0;
   int num_checks = 0;
   logic [1:0] md [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
   always #5 mclk_in = ~mclk_in;
   sdbs_top dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .failsafe_digital_input_a_in(ch_a), .failsafe_digital_input_b_in(ch_b),
      .failsafe_ack_input_in(fs_ack), .fieldbus_cw1_in(cw1),
      .run_command_in(run), .quick_stop_command_in(qstop_n),
      .standstill_in(still), .brake_diag_in(diag),
      .safe_torque_off_out(safe_torque_off), .safe_brake_control_out(safe_brake_control),
      .brake_close_out(close), .quick_stop_ramp_out(ramp),
      .motor_on_out(motor), .stop_a_out(stop_a),
      .discrepancy_fault_out(dfault), .brake_fault_out(bfault));
   sdbs_ctrl_model ctl (.mclk_in(mclk_in), .chan_a_out(ch_a),
      .chan_b_out(ch_b), .fs_ack_out(fs_ack), .cw1_out(cw1), .run_out(run),
      .qstop_n_out(qstop_n), .still_out(still), .diag_out(diag));
   task automatic final_report();
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s exp %h got %h", nm, e, g);
         fails++;
      end
   endtask
   // Bounded wait for a ready edge; a hang ends the run
   task automatic wait_rdy();
      int i;
      i = 0;
      @(posedge mclk_in);
      while (hreadyout !== 1'b1) begin
         i++;
         if (i > 50) begin
            fails++;
            final_report();
         end
         @(posedge mclk_in);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a,
      input logic [31:0] d);
      @(posedge mclk_in);
      hsel <= 1'b1;
      hsize <= 3'h2;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rchk(input logic [31:0] a, m, e, input string nm);
      ahb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd & m);
   endtask
   task automatic start();
      ahb(1'b1, `SDBS_ADDR_CMD, 32'h0000_0001);
      ctl.restart();
   endtask
   initial begin
      repeat (6) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      ctl.tick(5);
      rchk(`SDBS_ADDR_TOL, 32'hFFFF_FFFF, `SDBS_TOL_RST, "tol");
      rchk(`SDBS_ADDR_S1DLY, 32'hFFFF_FFFF, `SDBS_S1DLY_RST, "dly");
      rchk(32'h0000_0100, 32'hFFFF_FFFF, 32'h0000_0000, "hole");
      ahb(1'b1, `SDBS_ADDR_TOL, 32'h0000_000A);
      ahb(1'b1, `SDBS_ADDR_CTRL, 32'h0000_000C);
      start();
      chk("motor", 1, motor);
      ctl.set_ch(1'b0, 1'b0);
      chk("sto", 1, safe_torque_off);
      chk("sbc", 1, safe_brake_control);
      chk("close", 1, close);
      chk("motor_off", 0, motor);
      ctl.set_ch(1'b1, 1'b1);
      chk("sbc_off", 0, safe_brake_control);
      // One discrepancy round per setting and acknowledge kind
      for (int k = 0; k < 5; k++) begin
         ahb(1'b1, `SDBS_ADDR_CTRL, {28'h0, 2'h3, md[k]});
         ctl.set_ch(1'b0, 1'b1);
         ctl.set_ch(1'b1, 1'b1);
         chk("no_fault", 0, dfault);
         ctl.set_ch(1'b0, 1'b1);
         ctl.tick(15);
         chk("dfault", 1, dfault);
         if (k < 4) begin
            rchk(`SDBS_ADDR_FVAL, 32'hFFFF, `SDBS_FVAL_STO, "fval");
            rchk(`SDBS_ADDR_STAT, 32'hC, 32'h8, "event");
         end else
            rchk(`SDBS_ADDR_STAT, 32'hC, 32'h4, "ext");
         ctl.set_ch(1'b1, 1'b1);
         chk("lock", 1, safe_torque_off);
         rchk(`SDBS_ADDR_STAT, 32'h10, 32'h10, "lockbit");
         case (k)
            0: ctl.ack_terms();
            1: ctl.pulse_cw(`SDBS_CW_STO);
            2: ctl.pulse_cw(`SDBS_CW_SS1);
            3: ctl.pulse_cw(`SDBS_CW_ACK);
            default: ctl.pulse_ack();
         endcase
         rchk(`SDBS_ADDR_STAT, 32'h1C, 32'h0, "clr");
         start();
         chk("dclr", 0, dfault);
         chk("restart", 1, motor);
      end
      // Controlled stop: standstill first, then delay expiry
      ahb(1'b1, `SDBS_ADDR_CTRL, 32'h0000_000D);
      ahb(1'b1, `SDBS_ADDR_S1DLY, 32'h0000_0014);
      for (int v = 0; v < 2; v++) begin
         start();
         ctl.set_still(1'b0);
         ctl.set_cw(`SDBS_CW_SS1, 1'b0);
         chk("ramp", 1, ramp);
         chk("sto_early", 0, safe_torque_off);
         if (v == 0)
            ctl.set_still(1'b1);
         else
            ctl.tick(25);
         chk("sto_late", 1, safe_torque_off);
         chk("brake", 1, close);
         chk("hold_off", 0, motor);
         ctl.set_cw(`SDBS_CW_SS1, 1'b1);
         ctl.set_still(1'b1);
      end
      start();
      ctl.set_qstop(1'b0);
      chk("qstop", 0, motor);
      ctl.set_qstop(1'b1);
      for (int b = 0; b < 4; b++) begin
         ctl.set_diag(4'h1 << b);
         chk("bfault", 1, bfault);
         chk("stop_a", 1, stop_a);
         chk("bclose", 1, close);
         ctl.set_diag(4'h0);
         chk("bsticky", 1, bfault);
         ahb(1'b1, `SDBS_ADDR_CMD, 32'h0000_0002);
         ctl.tick(3);
         chk("bclr", 0, bfault);
      end
      final_report();
   end
endmodule // tb
`default_nettype wire

// >>> pkg/sdbs_defines.vh
// Constants for the discrepancy and brake supervisor.
// Assumes inclusion by bare name from the design files that use it.
`ifndef SDBS_DEFINES_VH
`define SDBS_DEFINES_VH
// Register byte offsets
`define SDBS_ADDR_CTRL 12'h000
`define SDBS_ADDR_TOL 12'h004
`define SDBS_ADDR_S1DLY 12'h008
`define SDBS_ADDR_STAT 12'h00C
`define SDBS_ADDR_FVAL 12'h010
`define SDBS_ADDR_CMD 12'h014
// Control field positions
`define SDBS_CTRL_MODE_LSB 0
`define SDBS_CTRL_MODE_MSB 1
`define SDBS_CTRL_BRK_FN 2
`define SDBS_CTRL_SBC_EN 3
`define SDBS_CTRL_W 4
// Settings
`define SDBS_MODE_BAS_TERM 2'h0
`define SDBS_MODE_BAS_FB 2'h1
`define SDBS_MODE_EXT_FB 2'h2
`define SDBS_MODE_EXT_TERM 2'h3
// Fault values
`define SDBS_FVAL_STO 16'h07D0
`define SDBS_FVAL_SS1 16'h07D2
// Fieldbus control word bits
`define SDBS_CW_STO 0
`define SDBS_CW_SS1 1
`define SDBS_CW_ACK 7
// Reset values
`define SDBS_TOL_RST 32'h0000_03E8
`define SDBS_S1DLY_RST 32'h0001_86A0
// Command register bits
`define SDBS_CMD_STD_ACK 0
`define SDBS_CMD_BRK_CLR 1
// Pulse sequencer states
`define SDBS_SEQ_IDLE 2'h0
`define SDBS_SEQ_MID 2'h1
`define SDBS_SEQ_W 2
// Brake fault codes
`define SDBS_BF_SHORT 0
`define SDBS_BF_XC24 1
`define SDBS_BF_OPEN 2
`define SDBS_BF_GND 3
`endif

// >>> src/sdbs_pulse_seq.v
// Detects a level-change-level pulse sequence on one input.
// Pattern a -> !a -> a where a is IDLE_LVL; input is synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "sdbs_defines.vh"
module sdbs_pulse_seq #(
   parameter IDLE_LVL = 1'b1
) (
   input wire mclk_in,
   input wire reset_n_in,
   input wire sig_in,
   output wire done_out
);
   //***************************************************
   // Sequencer
   //***************************************************
   reg [`SDBS_SEQ_W-1:0] state_ff; // Waiting for away or return
   reg [`SDBS_SEQ_W-1:0] nxt_state;
   reg prev_ff; // Previous sample of the input
   reg done_ff; // One-cycle pulse on completion
   reg nxt_done;

   // Starts only from an idle level seen before the away level
   always @* begin
      nxt_state = state_ff;
      nxt_done = 1'b0;
      case (state_ff)
         `SDBS_SEQ_IDLE: begin
            if (prev_ff == IDLE_LVL && sig_in != IDLE_LVL) begin
               nxt_state = `SDBS_SEQ_MID;
            end
         end
         `SDBS_SEQ_MID: begin
            if (sig_in == IDLE_LVL) begin
               nxt_state = `SDBS_SEQ_IDLE;
               nxt_done = 1'b1;
            end
         end
         default: begin
            nxt_state = `SDBS_SEQ_IDLE;
         end
      endcase
   end

   // Previous sample starts at the away level so reset is no edge
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_ff <= `SDBS_SEQ_IDLE;
         prev_ff <= ~IDLE_LVL;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         prev_ff <= sig_in;
         done_ff <= nxt_done;
      end
   end
   assign done_out = done_ff;
endmodule // sdbs_pulse_seq
`default_nettype wire

// >>> src/sdbs_sync.v
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes levels stay stable for several clocks.
`timescale 1ns/1ns
`default_nettype none
module sdbs_sync #(
   parameter W = 8
) (
   input wire mclk_in,
   input wire reset_n_in,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   //***************************************************
   // Synchroniser stages
   //***************************************************
   reg [W-1:0] meta_ff; // First stage, read only by second
   reg [W-1:0] sync_ff; // Second stage, safe to use

   // Both stages reset to zero, the safe level
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end
   assign sync_out = sync_ff;
endmodule // sdbs_sync
`default_nettype wire

// >>> src/sdbs_top.v
// Discrepancy supervisor and safe brake control with AHB-Lite registers.
// Assumes one clock; pins asynchronous; single-word AHB transfers.
// Behaviour
// - Channel discrepancy activates safe torque off
// - Basic handling in three listed settings
// - Basic setting reports fault value 2000/2002
// - Basic setting sets internal event bit
// - Discrepant input evaluated zero until acknowledge
// - Input high-low-high clears internal event
// - Fieldbus word bits 0/1 pulse clear event
// - Fieldbus bit 7 low-high-low acknowledges
// - Extended terminals: no internal event bit
// - Extended terminals: distinct discrepancy fault
// - Extended terminals: input low-high-low pulse acknowledges
// - Brake control needs function, enable, torque-off
// - No switch-on while torque-off or stop selected
// - Stop ramps down, brake closes at standstill
// - Stop: torque-off at standstill or delay
// - Torque-off while rotating closes brake immediately
// - Brake circuit checked on open and close
// - Short, 24 V cross, open, ground faults
// - Brake fault: stop A, message, close brake
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "sdbs_defines.vh"
module sdbs_top (
   input wire mclk_in,
   input wire reset_n_in,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // Safety pins
   input wire failsafe_digital_input_a_in,
   input wire failsafe_digital_input_b_in,
   input wire failsafe_ack_input_in,
   input wire [15:0] fieldbus_cw1_in,
   input wire run_command_in,
   input wire quick_stop_command_in,
   input wire standstill_in,
   input wire [3:0] brake_diag_in,
   // Outputs
   output wire safe_torque_off_out,
   output wire safe_brake_control_out,
   output wire brake_close_out,
   output wire quick_stop_ramp_out,
   output wire motor_on_out,
   output wire stop_a_out,
   output wire discrepancy_fault_out,
   output wire brake_fault_out
);
   //***************************************************
   // Input synchronisation
   //***************************************************
   wire [25:0] pins_s; // Synchronised pins
   sdbs_sync #(.W(26)) u_sync (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .async_in({failsafe_digital_input_a_in, failsafe_digital_input_b_in,
                 failsafe_ack_input_in, fieldbus_cw1_in, run_command_in,
                 quick_stop_command_in, standstill_in, brake_diag_in}),
      .sync_out(pins_s)
   );
   wire fdi_a = pins_s[25]; // Channel A, high = not selected
   wire fdi_b = pins_s[24]; // Channel B
   wire ack_pin = pins_s[23]; // Failsafe acknowledge input
   wire [15:0] cw1 = pins_s[22:7]; // Fieldbus control word 1
   wire run_cmd = pins_s[6];
   wire qstop_cmd = pins_s[5]; // Active low quick stop
   wire standstill = pins_s[4];
   wire [3:0] brk_diag = pins_s[3:0];
   //***************************************************
   // Registers
   //***************************************************
   reg [`SDBS_CTRL_W-1:0] ctrl_ff; // Mode, brake function, brake enable
   reg [31:0] tol_ff; // Discrepancy tolerance in cycles
   reg [31:0] s1dly_ff; // Stop delay in cycles
   reg [31:0] tol_cnt_ff; // Tolerance counter
   reg [31:0] s1_cnt_ff; // Stop delay counter
   reg disc_fault_ff; // Sticky discrepancy flag
   reg ext_fault_ff; // Sticky extended discrepancy flag
   reg int_event_ff; // Internal event bit
   reg fdi_lock_ff; // Evaluation held at zero
   reg [15:0] fval_ff; // Fault value
   reg brk_fault_ff; // Sticky brake fault
   reg [3:0] brk_code_ff; // Which brake fault
   reg s1_sto_ff; // Stop reached torque-off
   reg motor_on_ff; // Motor switched on
   reg run_prev_ff; // Run command history
   reg std_ack_ff; // Standard acknowledge seen
   reg [31:0] rdata_ff;
   reg dphase_ff; // Data phase pending, read or write
   reg [11:0] waddr_ff;
   reg hwrite_c; // Captured write direction
   // Mode decode, used more than once
   function is_basic;
      input [1:0] m;
      begin
         is_basic = (m != `SDBS_MODE_EXT_TERM);
      end
   endfunction
   function is_fb;
      input [1:0] m;
      begin
         is_fb = (m == `SDBS_MODE_BAS_FB) || (m == `SDBS_MODE_EXT_FB);
      end
   endfunction
   wire [1:0] mode = ctrl_ff[`SDBS_CTRL_MODE_MSB:`SDBS_CTRL_MODE_LSB];
   //***************************************************
   // Acknowledge sequences
   //***************************************************
   wire fdi_eval = fdi_a & fdi_b; // Both high = deselected
   wire seq_fdi, seq_cw0, seq_cw1, seq_cw7, seq_ackpin;
   sdbs_pulse_seq #(.IDLE_LVL(1'b1)) u_seq_fdi (.mclk_in(mclk_in),
   // Only agreed selection arms the acknowledge
      .reset_n_in(reset_n_in), .sig_in(fdi_a | fdi_b), .done_out(seq_fdi));
   sdbs_pulse_seq #(.IDLE_LVL(1'b1)) u_seq_cw0 (.mclk_in(mclk_in),
      .reset_n_in(reset_n_in), .sig_in(cw1[`SDBS_CW_STO]),
      .done_out(seq_cw0));
   sdbs_pulse_seq #(.IDLE_LVL(1'b1)) u_seq_cw1 (.mclk_in(mclk_in),
      .reset_n_in(reset_n_in), .sig_in(cw1[`SDBS_CW_SS1]),
      .done_out(seq_cw1));
   sdbs_pulse_seq #(.IDLE_LVL(1'b0)) u_seq_cw7 (.mclk_in(mclk_in),
      .reset_n_in(reset_n_in), .sig_in(cw1[`SDBS_CW_ACK]),
      .done_out(seq_cw7));
   sdbs_pulse_seq #(.IDLE_LVL(1'b0)) u_seq_ack (.mclk_in(mclk_in),
      .reset_n_in(reset_n_in), .sig_in(ack_pin), .done_out(seq_ackpin));
   // Clear event paths by setting
   wire fb_clear = is_fb(mode) & (seq_cw0 | seq_cw1 | seq_cw7);
   wire basic_clear = is_basic(mode) & (seq_fdi | fb_clear);
   wire ext_clear = ~is_basic(mode) & seq_ackpin;
   //***************************************************
   // Discrepancy supervision
   //***************************************************
   wire disagree = fdi_a ^ fdi_b;
   wire tol_hit = disagree && (tol_cnt_ff >= tol_ff);
   // Stop select from fieldbus in fieldbus settings, active low
   wire ss1_sel = is_fb(mode) & ~cw1[`SDBS_CW_SS1];
   wire sto_sel = ~fdi_eval | fdi_lock_ff | disagree
                  | (is_fb(mode) & ~cw1[`SDBS_CW_STO]);
   // Counter restarts on first disagreement, cancels on agreement
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tol_cnt_ff <= 32'h0000_0000;
      end else if (!disagree) begin
         tol_cnt_ff <= 32'h0000_0000;
      end else if (!tol_hit) begin
         tol_cnt_ff <= tol_cnt_ff + 32'h0000_0001;
      end
   end
   // Fault latching; a new expiry wins over a clear
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         disc_fault_ff <= 1'b0;
         ext_fault_ff <= 1'b0;
         int_event_ff <= 1'b0;
         fdi_lock_ff <= 1'b0;
         fval_ff <= 16'h0000;
      end else if (tol_hit && is_basic(mode)) begin
         disc_fault_ff <= 1'b1;
         int_event_ff <= 1'b1;
         fdi_lock_ff <= 1'b1;
         fval_ff <= ss1_sel ? `SDBS_FVAL_SS1 : `SDBS_FVAL_STO;
      end else if (tol_hit) begin
         ext_fault_ff <= 1'b1;
         fdi_lock_ff <= 1'b1;
      end else if ((basic_clear || ext_clear) && !disagree) begin
         disc_fault_ff <= 1'b0;
         ext_fault_ff <= 1'b0;
         int_event_ff <= 1'b0;
         fdi_lock_ff <= 1'b0;
      end
   end
   //***************************************************
   // Controlled stop and brake
   //***************************************************
   wire brake_diag_any = |brk_diag;
   // Stop counter runs while stop selected and not yet at torque-off
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s1_cnt_ff <= 32'h0000_0000;
         s1_sto_ff <= 1'b0;
      end else if (!ss1_sel) begin
         s1_cnt_ff <= 32'h0000_0000;
         s1_sto_ff <= 1'b0;
      end else if (standstill || s1_cnt_ff >= s1dly_ff) begin
         s1_sto_ff <= 1'b1;
      end else begin
         s1_cnt_ff <= s1_cnt_ff + 32'h0000_0001;
      end
   end
   wire sto_act = sto_sel | s1_sto_ff | brk_fault_ff;
   wire sbc_act = ctrl_ff[`SDBS_CTRL_BRK_FN] & ctrl_ff[`SDBS_CTRL_SBC_EN]
                  & sto_act;
   // Brake closes on torque-off regardless of speed, at stop standstill
   wire brake_close = sbc_act | sto_act
                      | (ss1_sel & standstill)
                      | brk_fault_ff | ~motor_on_ff;
   // Diagnostics sampled whenever the brake is driven either way
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         brk_fault_ff <= 1'b0;
         brk_code_ff <= 4'h0;
      end else if (brake_diag_any) begin
         brk_fault_ff <= 1'b1;
         brk_code_ff <= brk_code_ff | brk_diag;
      end else if (dphase_ff && hwrite_c && waddr_ff == `SDBS_ADDR_CMD
                   && hwdata[`SDBS_CMD_BRK_CLR]) begin
         brk_fault_ff <= 1'b0;
         brk_code_ff <= 4'h0;
      end
   end
   // Motor on needs run rising edge, no selection, standard ack done
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         motor_on_ff <= 1'b0;
         run_prev_ff <= 1'b1;
         std_ack_ff <= 1'b1;
      end else begin
         run_prev_ff <= run_cmd;
         if (disc_fault_ff || ext_fault_ff) begin
            std_ack_ff <= 1'b0;
         end else if (dphase_ff && hwrite_c && waddr_ff == `SDBS_ADDR_CMD
                      && hwdata[`SDBS_CMD_STD_ACK]) begin
            std_ack_ff <= 1'b1;
         end
         if (sto_act || ss1_sel || !run_cmd || !qstop_cmd) begin
            motor_on_ff <= 1'b0;
         end else if (run_cmd && !run_prev_ff && std_ack_ff) begin
            motor_on_ff <= 1'b1;
         end
      end
   end
   //***************************************************
   // AHB-Lite slave, zero wait states
   //***************************************************
   wire acc = hsel & htrans[1] & hready;
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dphase_ff <= 1'b0;
         hwrite_c <= 1'b0;
         waddr_ff <= 12'h000;
         rdata_ff <= 32'h0000_0000;
      end else begin
         dphase_ff <= acc;
         hwrite_c <= acc & hwrite;
         waddr_ff <= haddr[11:0];
         rdata_ff <= 32'h0000_0000;
         if (acc && !hwrite) begin
            case (haddr[11:0])
               `SDBS_ADDR_CTRL: rdata_ff <= {28'h000_0000, ctrl_ff};
               `SDBS_ADDR_TOL: rdata_ff <= tol_ff;
               `SDBS_ADDR_S1DLY: rdata_ff <= s1dly_ff;
               `SDBS_ADDR_STAT: rdata_ff <= {20'h0_0000, brk_code_ff,
                  motor_on_ff, sbc_act, sto_act, fdi_lock_ff,
                  int_event_ff, ext_fault_ff, disc_fault_ff, brk_fault_ff};
               `SDBS_ADDR_FVAL: rdata_ff <= {16'h0000, fval_ff};
               default: rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end
   // Writable configuration registers
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctrl_ff <= {`SDBS_CTRL_W{1'b0}};
         tol_ff <= `SDBS_TOL_RST;
         s1dly_ff <= `SDBS_S1DLY_RST;
      end else if (dphase_ff && hwrite_c) begin
         case (waddr_ff)
            `SDBS_ADDR_CTRL: ctrl_ff <= hwdata[`SDBS_CTRL_W-1:0];
            `SDBS_ADDR_TOL: tol_ff <= hwdata;
            `SDBS_ADDR_S1DLY: s1dly_ff <= hwdata;
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end
   assign hrdata = rdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   //***************************************************
   // Outputs
   //***************************************************
   assign safe_torque_off_out = sto_act;
   assign safe_brake_control_out = sbc_act;
   assign brake_close_out = brake_close;
   assign quick_stop_ramp_out = ss1_sel & ~s1_sto_ff;
   assign motor_on_out = motor_on_ff;
   assign stop_a_out = brk_fault_ff;
   assign discrepancy_fault_out = disc_fault_ff | ext_fault_ff;
   assign brake_fault_out = brk_fault_ff;
   wire unused_ok = &{1'b0, hsize, haddr[31:12], brk_diag};
endmodule // sdbs_top
`default_nettype wire
